// ==== pkg/rsq_pkg.sv ====
package rsq_pkg;

    // release hold of the reset indication, in processor clocks
    localparam int unsigned IND_HOLD_CYCLES = 512;

    // pin levels that count as asserted
    localparam logic BOOT_CFG_ACTIVE = 1'b1;
    localparam logic TEST_ACTIVE     = 1'b1;

    typedef enum logic [3:0] {
        ST_RESET  = 4'h1,
        ST_SAMPLE = 4'h2,
        ST_NORMAL = 4'h4,
        ST_PROG   = 4'h8
    } rsq_state_t;

    typedef struct packed {
        logic [1:0] rel_sync;
        logic       cfg_meta;
        logic       cfg_sync;
        logic       tst_meta;
        logic       tst_sync;
        rsq_state_t st;
        logic       core_rst_n;
        logic       periph_rst_n;
        logic       ind_n;
        logic       prog;
        logic       normal;
        logic       grant;
        logic       tst_latched;
        logic       mirror_pos;
    } rsq_top_st_t;

    localparam rsq_top_st_t TOP_RST = '{
        rel_sync:     2'h0,
        cfg_meta:     1'b0,
        cfg_sync:     1'b0,
        tst_meta:     1'b0,
        tst_sync:     1'b0,
        st:           ST_RESET,
        core_rst_n:   1'b0,
        periph_rst_n: 1'b0,
        ind_n:        1'b0,
        prog:         1'b0,
        normal:       1'b0,
        grant:        1'b0,
        tst_latched:  1'b0,
        mirror_pos:   1'b0
    };

    // programming mode wants the config pin asserted and the test pin negated
    function automatic logic rsq_prog_cond(input logic cfg, input logic tst);
        return (cfg == BOOT_CFG_ACTIVE) && (tst != TEST_ACTIVE);
    endfunction

endpackage

// ==== pkg/rsq_seq_if.sv ====
interface rsq_seq_if;
    logic hold;
    logic done;

    modport ctl (
        output hold,
        input  done
    );

    modport cnt (
        input  hold,
        output done
    );
endinterface

// ==== design/rsq_rst_stretch.sv ====
module rsq_rst_stretch
    import rsq_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = IND_HOLD_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // sequencer link
    rsq_seq_if.cnt   seq
);

    localparam int unsigned CW = $clog2(HOLD_CYCLES) + 1;
    localparam logic [CW-1:0] CNT_LAST = CW'(HOLD_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          done;
    } rsq_cnt_st_t;

    rsq_cnt_st_t q;
    rsq_cnt_st_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // counts enabled edges after hold drops; done is set on the last-but-one so
    // the registered indication in the sequencer lands exactly on the count
    always_comb begin
        n = q;
        if (clk_en) begin
            if (seq.hold) begin
                n.cnt  = '0;
                n.done = 1'b0;
            end else if (!q.done) begin
                n.cnt  = q.cnt + 1'b1;
                n.done = (n.cnt == CNT_LAST); // RULE2
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign seq.done = q.done;

    ////////////////////////////////////////////////////////////////////////////////
    hold_clears_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        (seq.hold && clk_en) |=> (!q.done && q.cnt == '0))
        else $error("hold did not clear the release counter");

    done_stays_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        (q.done && !seq.hold) |=> q.done)
        else $error("release counter dropped done without a hold");

endmodule

// ==== design/rsq_top.sv ====
// Summary of operation
// (RULE1) A low on the external reset pin puts core and peripherals in reset at once, unclocked.
// (RULE2) The reset indication stays low until 512 clocks after the last reset source goes away; the code counts them from core reset release instead.
// (RULE3) Config pin asserted and test pin negated at reset exit selects flash programming mode.
// (RULE4) In flash programming mode the serial flash programming port is granted the flash.
// (RULE5) The clock mirror output follows the system clock in frequency and phase.
// (RULE6) The board keeps the factory test pin grounded during normal operation.
// (RULE7) Mode pins are sampled only at reset exit; anything but the programming case is normal.
module rsq_top
    import rsq_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = IND_HOLD_CYCLES
) (
    // clock, reset, enable
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // board pins
    input  wire logic ext_reset_in_n,
    input  wire logic boot_config_select,
    input  wire logic factory_test_in,
    // on-chip reset requests, same clock
    input  wire logic soft_reset_req,
    // resets out
    output logic      core_reset_n,
    output logic      periph_reset_n,
    output logic      reset_indicate_out_n,
    // mode
    output logic      normal_mode,
    output logic      flash_prog_mode,
    output logic      serial_flash_port_grant,
    output logic      factory_test_latched,
    // clock mirror pin
    output logic      system_clock_mirror
);

    logic        arst_n;
    logic        mirror_neg_q;
    rsq_top_st_t q;
    rsq_top_st_t n;

    rsq_seq_if seq ();

    ////////////////////////////////////////////////////////////////////////////////
    // the pin reset is merged into the async reset so assertion needs no clock;
    // release is only seen through the two-stage rel_sync chain
    assign arst_n = rst_n & ext_reset_in_n; // RULE1

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        if (clk_en) begin
            n.rel_sync   = {q.rel_sync[0], 1'b1};
            n.cfg_meta   = boot_config_select;
            n.cfg_sync   = q.cfg_meta;
            n.tst_meta   = factory_test_in;
            n.tst_sync   = q.tst_meta;
            n.mirror_pos = ~q.mirror_pos; // RULE5
            case (q.st)
                ST_RESET: begin
                    // mode pins are synced by the time rel_sync[1] rises
                    if (q.rel_sync[1] && !soft_reset_req) begin
                        n.st = ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    n.tst_latched  = (q.tst_sync == TEST_ACTIVE); // RULE7
                    n.core_rst_n   = 1'b1;
                    n.periph_rst_n = 1'b1;
                    if (rsq_prog_cond(q.cfg_sync, q.tst_sync)) begin // RULE3
                        n.st    = ST_PROG;
                        n.prog  = 1'b1;
                        n.grant = 1'b1; // RULE4
                    end else begin
                        n.st     = ST_NORMAL; // RULE7
                        n.normal = 1'b1;
                    end
                end
                ST_NORMAL, ST_PROG: begin
                    // mode is held until the next reset; pins are ignored here
                    if (soft_reset_req) begin
                        n.st           = ST_RESET;
                        n.core_rst_n   = 1'b0;
                        n.periph_rst_n = 1'b0;
                        n.prog         = 1'b0;
                        n.normal       = 1'b0;
                        n.grant        = 1'b0;
                    end
                end
                default: begin
                    n = TOP_RST;
                end
            endcase
            n.ind_n = seq.done & n.core_rst_n; // RULE2
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= TOP_RST; // RULE1
        end else begin
            q <= n;
        end
    end

    // second half of the mirror; a gated copy of the clock net would put a
    // glitch path on the pad, two toggles keep it a flop-driven signal
    always_ff @(negedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mirror_neg_q <= 1'b0;
        end else if (clk_en) begin
            mirror_neg_q <= q.mirror_pos; // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // release counter sees the core reset as its hold
    assign seq.hold = ~q.core_rst_n; // RULE2

    rsq_rst_stretch #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_stretch (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .seq     (seq.cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign core_reset_n            = q.core_rst_n;
    assign periph_reset_n          = q.periph_rst_n;
    assign reset_indicate_out_n    = q.ind_n;
    assign normal_mode             = q.normal;
    assign flash_prog_mode         = q.prog;
    assign serial_flash_port_grant = q.grant;
    assign factory_test_latched    = q.tst_latched;
    assign system_clock_mirror     = q.mirror_pos ^ mirror_neg_q;

    ////////////////////////////////////////////////////////////////////////////////
    // helper: enabled edges since the core reset released, saturating
    localparam int unsigned HW = $clog2(HOLD_CYCLES) + 1;
    localparam logic [HW-1:0] HOLD_W = HW'(HOLD_CYCLES);
    logic [HW-1:0] rel_cnt_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rel_cnt_q <= '0;
        end else if (clk_en) begin
            if (!q.core_rst_n) begin
                rel_cnt_q <= '0;
            end else if (rel_cnt_q != HOLD_W) begin
                rel_cnt_q <= rel_cnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin reset check is gated by power-on reset only, so a lost pin merge shows up

    pin_reset_now_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
        !ext_reset_in_n |-> (!core_reset_n && !periph_reset_n && !reset_indicate_out_n))
        else $error("pin reset did not hold core and peripherals");

    resets_paired_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE1
        core_reset_n == periph_reset_n)
        else $error("core and peripheral resets differ");

    ind_release_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        $rose(reset_indicate_out_n) |-> (rel_cnt_q == HOLD_W))
        else $error("reset indication released at the wrong count");

    ind_early_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        (reset_indicate_out_n |-> (core_reset_n && rel_cnt_q == HOLD_W)))
        else $error("reset indication high before the hold ran out");

    ind_in_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        !core_reset_n |-> !reset_indicate_out_n)
        else $error("reset indication high while the core is in reset");

    soft_reset_now_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        (clk_en && soft_reset_req && (q.st == ST_NORMAL || q.st == ST_PROG)) |=>
            (!core_reset_n && !reset_indicate_out_n && !normal_mode && !flash_prog_mode))
        else $error("soft reset request did not reset at once");

    freeze_state_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE2
        !clk_en |=> $stable(q))
        else $error("state moved while the clock enable was low");

    prog_entry_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE3
        (clk_en && q.st == ST_SAMPLE) |=>
            (flash_prog_mode == rsq_prog_cond($past(q.cfg_sync), $past(q.tst_sync))))
        else $error("programming mode decision does not match pins at exit");

    port_grant_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
        (serial_flash_port_grant == (flash_prog_mode && core_reset_n)))
        else $error("flash port grant does not follow programming mode");

    mode_in_reset_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE4
        !core_reset_n |-> !(normal_mode || flash_prog_mode || serial_flash_port_grant))
        else $error("a mode is active while the core is in reset");

    mirror_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE5
        (clk_en && $past(clk_en) && core_reset_n) |-> !system_clock_mirror)
        else $error("clock mirror not low ahead of rising edge");

    mirror_high_a: assert property (@(negedge ref_clk) disable iff (!arst_n) // RULE5
        (clk_en && core_reset_n) |-> system_clock_mirror)
        else $error("clock mirror not high ahead of falling edge");

    test_latch_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
        (clk_en && q.st == ST_SAMPLE) |=>
            (factory_test_latched == $past(q.tst_sync)))
        else $error("test pin level not captured at reset exit");

    sample_exit_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
        (clk_en && q.st == ST_SAMPLE) |=> (core_reset_n && periph_reset_n))
        else $error("reset exit did not follow the sampling cycle");

    mode_held_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE7
        (core_reset_n && $past(core_reset_n)) |->
            ($stable(flash_prog_mode) && $stable(normal_mode) &&
             (normal_mode != flash_prog_mode)))
        else $error("mode changed outside reset exit");

endmodule

// ==== testbench/rsq_board_model.sv ====
module rsq_board_model (
    // clock and observed reset
    input  wire logic ref_clk,
    input  wire logic core_reset_n,
    // bench commands
    input  wire logic req_rst,
    input  wire logic req_cfg,
    input  wire logic req_tst,
    // board pins
    output logic      ext_reset_in_n,
    output logic      boot_config_select,
    output logic      factory_test_in
);
    timeunit 1ns;
    timeprecision 100ps;

    logic cfg_q = 1'b1;
    logic tst_q = 1'b0;

    // reset pin follows the command with no clock in between
    assign ext_reset_in_n = ~req_rst;
    assign boot_config_select = cfg_q;
    // test pin stays grounded unless a case asks otherwise
    assign factory_test_in = tst_q;

    // levels follow the commands while reset is held and go back to idle after exit, so they are steady across the exit
    always @(posedge ref_clk) begin
        if (req_rst) begin
            cfg_q <= req_cfg;
            tst_q <= req_tst;
        end else if (core_reset_n === 1'b1) begin
            // config pin let go after exit: its pull-up takes over
            cfg_q <= 1'b1;
            // test pin back to ground for normal operation
            tst_q <= 1'b0;
        end
    end
endmodule

// ==== testbench/reset_and_boot_mode_sequencer_test.sv ====
module reset_and_boot_mode_sequencer_test import rsq_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HOLD = 8;
    typedef struct {logic cfg; logic tst; logic [3:0] exp;} rsq_row_t;
    // expected: normal, programming, grant, test latched
    rsq_row_t rows [4] = '{'{1'b0, 1'b0, 4'h8}, '{1'b1, 1'b0, 4'h6},
                           '{1'b0, 1'b1, 4'h9}, '{1'b1, 1'b1, 4'h9}};

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic soft_reset_req = 1'b0;
    logic req_rst = 1'b0;
    logic req_cfg = 1'b1;
    logic req_tst = 1'b0;
    logic ext_reset_in_n, boot_config_select, factory_test_in;
    logic core_reset_n, periph_reset_n, reset_indicate_out_n;
    logic normal_mode, flash_prog_mode, serial_flash_port_grant;
    logic factory_test_latched, system_clock_mirror;
    logic [3:0] modes;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    assign modes = {normal_mode, flash_prog_mode, serial_flash_port_grant, factory_test_latched};

    always #2 ref_clk = ~ref_clk;

    rsq_top #(.HOLD_CYCLES(HOLD)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
        .ext_reset_in_n(ext_reset_in_n), .boot_config_select(boot_config_select),
        .factory_test_in(factory_test_in), .soft_reset_req(soft_reset_req),
        .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n),
        .reset_indicate_out_n(reset_indicate_out_n), .normal_mode(normal_mode),
        .flash_prog_mode(flash_prog_mode), .serial_flash_port_grant(serial_flash_port_grant),
        .factory_test_latched(factory_test_latched), .system_clock_mirror(system_clock_mirror)
    );

    rsq_board_model u_board (
        .ref_clk(ref_clk), .core_reset_n(core_reset_n), .req_rst(req_rst),
        .req_cfg(req_cfg), .req_tst(req_tst), .ext_reset_in_n(ext_reset_in_n),
        .boot_config_select(boot_config_select), .factory_test_in(factory_test_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // bounded wait for exit, then count rising clock edges until the indication lets go
    task automatic await_release(output int cnt);
        int b;
        cnt = 0;
        b = 0;
        while (core_reset_n !== 1'b1 && b < 100) begin
            step(1);
            b++;
        end
        while (reset_indicate_out_n !== 1'b1 && b < 200) begin
            step(1);
            cnt++;
            b++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // run is about 150 cycles; this ceiling only trips on a hang
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            $display("[ERR] %0t run did not finish", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        step(12);
        check({core_reset_n, periph_reset_n, reset_indicate_out_n, modes}, 16'h0000);
        rst_n = 1'b1;
        await_release(n);
        check(16'(n), 16'(HOLD));
        check({core_reset_n, periph_reset_n, reset_indicate_out_n}, 3'h7);
        check(modes, 4'h6);
        for (int i = 0; i < 3; i++) begin
            check(system_clock_mirror, 1'b1);
            @(negedge ref_clk);
            #1;
            check(system_clock_mirror, 1'b0);
            step(1);
        end
        for (int i = 0; i < 4; i++) begin
            req_cfg = rows[i].cfg;
            req_tst = rows[i].tst;
            req_rst = 1'b1;
            #1;
            check({core_reset_n, periph_reset_n, reset_indicate_out_n, modes}, 16'h0000);
            step(3);
            req_rst = 1'b0;
            await_release(n);
            check(16'(n), 16'(HOLD));
            check(modes, rows[i].exp);
            step(5);
            check(modes, rows[i].exp);
        end
        // second source arrives mid-hold: the count must start over
        req_cfg = 1'b0;
        req_tst = 1'b0;
        req_rst = 1'b1;
        step(3);
        req_rst = 1'b0;
        step(6);
        soft_reset_req = 1'b1;
        step(1);
        soft_reset_req = 1'b0;
        check({core_reset_n, periph_reset_n, reset_indicate_out_n, modes}, 16'h0000);
        await_release(n);
        check(16'(n), 16'(HOLD));
        check(modes, 4'h6);
        // enable low mid-hold: count and mirror freeze; two enabled edges counted before it
        req_rst = 1'b1;
        step(3);
        req_rst = 1'b0;
        step(6);
        clk_en = 1'b0;
        step(3);
        @(negedge ref_clk);
        #1;
        check(system_clock_mirror, 1'b1);
        step(1);
        check(reset_indicate_out_n, 1'b0);
        clk_en = 1'b1;
        await_release(n);
        check(16'(n), 16'(HOLD - 2));
        check(modes, 4'h8);
        results();
    end
endmodule
